// ---- afe_pkg.sv ----
// Register map, field layout and reset values of the front-end control bank
package afe_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets, instance 0 then instance 1
  localparam logic [3:0] OFF_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_TRIM0 = 4'h1;
  localparam logic [3:0] OFF_DAH0 = 4'h2;
  localparam logic [3:0] OFF_DAL0 = 4'h3;
  localparam logic [3:0] OFF_DACC0 = 4'h4;
  localparam logic [3:0] OFF_CTRL1 = 4'h5;
  localparam logic [3:0] OFF_TRIM1 = 4'h6;
  localparam logic [3:0] OFF_DAH1 = 4'h7;
  localparam logic [3:0] OFF_DAL1 = 4'h8;
  localparam logic [3:0] OFF_DACC1 = 4'h9;
  localparam logic [3:0] OFF_PATH = 4'ha;
  // Field positions
  localparam int BIT_OUT_FLAG = 7;
  localparam int BIT_AMP_EN = 6;
  localparam int BIT_CAL_MODE = 7;
  localparam int BIT_REF_SEL = 6;
  localparam int BIT_CONV_EN = 7;
  // Reset values
  localparam logic [1:0] RST_BW = 2'h0;
  localparam logic [5:0] RST_TRIM = 6'h20;
  localparam logic [7:0] RST_PATH = 8'h00;
  localparam logic [11:0] RST_CODE = 12'h000;
endpackage

// ---- afe_channel.sv ----
// One amplifier plus converter instance of the control bank
`timescale 1ns/1ps
`default_nettype none
module afe_channel
  import afe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Decoded writes
  input wire logic wr_ctrl,
  input wire logic wr_trim,
  input wire logic wr_dah,
  input wire logic wr_dal,
  input wire logic wr_dacc,
  input wire logic [7:0] wdata,
  // Comparator state of the amplifier
  input wire logic amp_out,
  // Register views
  output logic [7:0] ctrl_rd,
  output logic [7:0] trim_rd,
  output logic [7:0] dah_rd,
  output logic [7:0] dal_rd,
  output logic [7:0] dacc_rd,
  // Analog controls
  output logic amp_enable,
  output logic [1:0] amp_bandwidth_sel,
  output logic offset_cal_mode,
  output logic cal_reference_sel,
  output logic [5:0] offset_trim_code,
  output logic converter_enable,
  output logic [11:0] converter_code,
  output logic conv_start
);
  logic [7:0] shadow_q;
  logic flag;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      amp_enable <= 1'b0;
      amp_bandwidth_sel <= RST_BW;
      offset_cal_mode <= 1'b0;
      cal_reference_sel <= 1'b0;
      offset_trim_code <= RST_TRIM;
      converter_enable <= 1'b0;
      converter_code <= RST_CODE;
      shadow_q <= 8'h00;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= wr_dah; // RULE_15
      if (wr_ctrl)
      begin
        amp_enable <= wdata[BIT_AMP_EN]; // RULE_05
        amp_bandwidth_sel <= wdata[1:0]; // RULE_06
      end
      if (wr_trim)
      begin
        offset_cal_mode <= wdata[BIT_CAL_MODE]; // RULE_08
        cal_reference_sel <= wdata[BIT_REF_SEL];
        offset_trim_code <= wdata[5:0]; // RULE_11
      end
      if (wr_dal)
        shadow_q <= wdata; // RULE_16
      if (wr_dah)
        converter_code <= {wdata[3:0], shadow_q}; // RULE_02 RULE_15
      if (wr_dacc)
        converter_enable <= wdata[BIT_CONV_EN]; // RULE_17
    end
  end

  // Flag gated so it reads zero outside calibration
  assign flag = offset_cal_mode & amp_out; // RULE_03 RULE_04
  assign ctrl_rd = {flag, amp_enable, 4'h0, amp_bandwidth_sel}; // RULE_07 RULE_18
  assign trim_rd = {offset_cal_mode, cal_reference_sel, offset_trim_code};
  assign dah_rd = {4'h0, converter_code[11:8]};
  assign dal_rd = converter_code[7:0];
  assign dacc_rd = {converter_enable, 7'h00};
endmodule
`default_nettype wire

// ---- afe_opamp_dac_control.sv ----
// Register bank controlling two amplifiers, two converters and the path switches
// Behaviour
// RULE_01: Two independent amplifier and converter instances
// RULE_02: Converter code is 12 bits, high/low split
// RULE_03: Output flag read-only, follows amplifier in calibration
// RULE_04: Output flag reads zero outside calibration
// RULE_05: Control bit 6 enables amplifier, resets 0
// RULE_06: Control bits 1:0 select bandwidth, reset 0
// RULE_07: Control bits 5:2 read zero, ignore writes
// RULE_08: Trim bit 7 selects calibration mode
// RULE_09: Amp0 reference: photodiode negative or positive input
// RULE_10: Amp1 reference: negative pin or half supply
// RULE_11: Trim bits 5:0 hold code, reset 100000
// RULE_12: Path bits 4:3 select stage1 feedback resistor
// RULE_13: Path bits 2:0 select stage2 resistor
// RULE_14: Path bits 7:5 close analog switches
// RULE_15: High write loads full code, starts conversion
// RULE_16: Low write fills shadow, copied on high write
// RULE_17: Converter control bit 7 enables converter
// RULE_18: Fields read back last write; flag ignores writes; low data reads the active code, not the shadow
`timescale 1ns/1ps
`default_nettype none
module afe_opamp_dac_control
  import afe_pkg::*;
#(
  parameter int N_CH = 2
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [afe_pkg::ADDR_W-1:0] addr,
  input wire logic [afe_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [afe_pkg::DATA_W-1:0] rdata,
  // Amplifier comparator states
  input wire logic [1:0] amp_out,
  // Amplifier controls
  output logic [1:0] amp_enable,
  output logic [3:0] amp_bandwidth_sel,
  output logic [1:0] offset_cal_mode,
  output logic [1:0] cal_reference_sel,
  output logic [11:0] offset_trim_code,
  // Path controls
  output logic amp1_neg_input_switch,
  output logic stage2_cap_switch,
  output logic stage2_res_switch,
  output logic [1:0] stage1_feedback_res_sel,
  output logic [2:0] stage2_gain_res_sel,
  // Converter controls
  output logic [1:0] converter_enable,
  output logic [11:0] converter_code0,
  output logic [11:0] converter_code1,
  output logic [1:0] conv_start
);
  import afe_pkg::*;

  // Write decode for one register, shared by every write target
  function automatic logic wr_hit(logic en, logic [3:0] a, logic [3:0] off);
    wr_hit = en && a == off;
  endfunction

  logic [7:0] path_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic [7:0] ctrl_rd [2];
  logic [7:0] trim_rd [2];
  logic [7:0] dah_rd [2];
  logic [7:0] dal_rd [2];
  logic [7:0] dacc_rd [2];
  logic [11:0] code_w [2];
  logic [3:0] base [2];

  assign base[0] = OFF_CTRL0;
  assign base[1] = OFF_CTRL1;

  genvar g;
  generate
    for (g = 0; g < N_CH; g++)
    begin : ch
      wire hit_ctrl = wr_hit(wr_en, addr, base[g]);
      wire hit_trim = wr_hit(wr_en, addr, base[g] + 4'h1);
      wire hit_dah = wr_hit(wr_en, addr, base[g] + 4'h2);
      wire hit_dal = wr_hit(wr_en, addr, base[g] + 4'h3);
      wire hit_dacc = wr_hit(wr_en, addr, base[g] + 4'h4);
      // Reference meaning differs per instance; the bit itself is common
      afe_channel u_ch ( // RULE_01 RULE_09 RULE_10
        .core_clk(core_clk),
        .rst(rst),
        .wr_ctrl(hit_ctrl),
        .wr_trim(hit_trim),
        .wr_dah(hit_dah),
        .wr_dal(hit_dal),
        .wr_dacc(hit_dacc),
        .wdata(wdata),
        .amp_out(amp_out[g]),
        .ctrl_rd(ctrl_rd[g]),
        .trim_rd(trim_rd[g]),
        .dah_rd(dah_rd[g]),
        .dal_rd(dal_rd[g]),
        .dacc_rd(dacc_rd[g]),
        .amp_enable(amp_enable[g]),
        .amp_bandwidth_sel(amp_bandwidth_sel[2*g +: 2]),
        .offset_cal_mode(offset_cal_mode[g]),
        .cal_reference_sel(cal_reference_sel[g]),
        .offset_trim_code(offset_trim_code[6*g +: 6]),
        .converter_enable(converter_enable[g]),
        .converter_code(code_w[g]),
        .conv_start(conv_start[g])
      );
    end
  endgenerate

  assign converter_code0 = code_w[0];
  assign converter_code1 = code_w[1];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      path_q <= RST_PATH;
    else if (wr_hit(wr_en, addr, OFF_PATH))
      path_q <= wdata; // RULE_12 RULE_13 RULE_14
  end

  assign amp1_neg_input_switch = path_q[7]; // RULE_14
  assign stage2_cap_switch = path_q[6];
  assign stage2_res_switch = path_q[5];
  assign stage1_feedback_res_sel = path_q[4:3]; // RULE_12
  assign stage2_gain_res_sel = path_q[2:0]; // RULE_13

  // Unmapped offsets read zero
  always_comb
  begin
    unique case (addr)
      OFF_CTRL0: rd_mux = ctrl_rd[0];
      OFF_TRIM0: rd_mux = trim_rd[0];
      OFF_DAH0: rd_mux = dah_rd[0];
      OFF_DAL0: rd_mux = dal_rd[0];
      OFF_DACC0: rd_mux = dacc_rd[0];
      OFF_CTRL1: rd_mux = ctrl_rd[1];
      OFF_TRIM1: rd_mux = trim_rd[1];
      OFF_DAH1: rd_mux = dah_rd[1];
      OFF_DAL1: rd_mux = dal_rd[1];
      OFF_DACC1: rd_mux = dacc_rd[1];
      OFF_PATH: rd_mux = path_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (rd_en)
      rdata_q <= rd_mux; // RULE_18
    else
      rdata_q <= 8'h00;
  end
  assign rdata = rdata_q;

  flag_zero_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
    rd_en && addr == OFF_CTRL0 && !offset_cal_mode[0] |=> !rdata[7])
    else $error("flag set outside calibration");
  flag_follow_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    rd_en && addr == OFF_CTRL1 |=> rdata[7] == $past(amp_out[1] & offset_cal_mode[1]))
    else $error("flag does not follow amplifier");
  ctrl_gap_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    rd_en && (addr == OFF_CTRL0 || addr == OFF_CTRL1) |=> rdata[5:2] == 4'h0)
    else $error("unused control bits nonzero");
  enable_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_05
    wr_en && addr == OFF_CTRL0 |=> amp_enable[0] == $past(wdata[6]))
    else $error("amplifier enable not written");
  code_load_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    wr_en && addr == OFF_DAH0 |=> conv_start[0] && converter_code0[11:8] == $past(wdata[3:0]))
    else $error("high write did not load code");
  shadow_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_16
    wr_en && addr == OFF_DAL1 |=> $stable(converter_code1))
    else $error("low write changed active code");
  trim_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_11
    wr_en && addr == OFF_TRIM1 |=> offset_trim_code[11:6] == $past(wdata[5:0]))
    else $error("trim code not written");
  path_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_12
    wr_en && addr == OFF_PATH |=> stage1_feedback_res_sel == $past(wdata[4:3]))
    else $error("feedback select not written");
  conv_en_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_17
    wr_en && addr == OFF_DACC1 |=> converter_enable[1] == $past(wdata[7]))
    else $error("converter enable not written");

  // Reset values, looked at on the first edge after release
  trim_reset_a: assert property (@(posedge core_clk) // RULE_11
    $fell(rst)
    |-> offset_trim_code == {RST_TRIM, RST_TRIM})
    else $error("trim code lost its reset value");
  ctrl_reset_a: assert property (@(posedge core_clk) // RULE_05
    $fell(rst)
    |-> amp_enable == 2'b00)
    else $error("amplifier enabled after reset");
  bw_reset_a: assert property (@(posedge core_clk) // RULE_06
    $fell(rst)
    |-> amp_bandwidth_sel == {RST_BW, RST_BW})
    else $error("bandwidth not at reset value");
  path_reset_a: assert property (@(posedge core_clk) // RULE_14
    $fell(rst)
    |-> {amp1_neg_input_switch, stage2_cap_switch, stage2_res_switch} == RST_PATH[7:5])
    else $error("analog switch closed after reset");
  sel_reset_a: assert property (@(posedge core_clk) // RULE_12
    $fell(rst)
    |-> {stage1_feedback_res_sel, stage2_gain_res_sel} == RST_PATH[4:0])
    else $error("resistor select not at reset value");
  code_reset_a: assert property (@(posedge core_clk) // RULE_02
    $fell(rst)
    |-> converter_code0 == RST_CODE && converter_code1 == RST_CODE)
    else $error("converter code not at reset value");
  conv_reset_a: assert property (@(posedge core_clk) // RULE_17
    $fell(rst)
    |-> converter_enable == 2'b00 && conv_start == 2'b00)
    else $error("converter active after reset");

  // Writes reach only the addressed instance
  isolate_trim_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_01
    wr_hit(wr_en, addr, OFF_TRIM0)
    |=> $stable(offset_trim_code[11:6]))
    else $error("trim write leaked into other instance");
  isolate_ctrl_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_01
    wr_hit(wr_en, addr, OFF_CTRL1)
    |=> $stable(amp_enable[0]) && $stable(amp_bandwidth_sel[1:0]))
    else $error("control write leaked into other instance");
  enable1_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_05
    wr_hit(wr_en, addr, OFF_CTRL1)
    |=> amp_enable[1] == $past(wdata[BIT_AMP_EN]))
    else $error("second amplifier enable not written");
  bw0_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_06
    wr_hit(wr_en, addr, OFF_CTRL0)
    |=> amp_bandwidth_sel[1:0] == $past(wdata[1:0]))
    else $error("bandwidth not written");
  bw1_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_06
    wr_hit(wr_en, addr, OFF_CTRL1)
    |=> amp_bandwidth_sel[3:2] == $past(wdata[1:0]))
    else $error("second bandwidth not written");
  mode_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_08
    wr_hit(wr_en, addr, OFF_TRIM0)
    |=> offset_cal_mode[0] == $past(wdata[BIT_CAL_MODE]))
    else $error("calibration mode not written");
  ref0_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_09
    wr_hit(wr_en, addr, OFF_TRIM0)
    |=> cal_reference_sel[0] == $past(wdata[BIT_REF_SEL]))
    else $error("reference select not written");
  ref1_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_10
    wr_hit(wr_en, addr, OFF_TRIM1)
    |=> cal_reference_sel[1] == $past(wdata[BIT_REF_SEL]))
    else $error("second reference select not written");
  trim0_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_11
    wr_hit(wr_en, addr, OFF_TRIM0)
    |=> offset_trim_code[5:0] == $past(wdata[5:0]))
    else $error("first trim code not written");
  gain_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_13
    wr_hit(wr_en, addr, OFF_PATH)
    |=> stage2_gain_res_sel == $past(wdata[2:0]))
    else $error("stage2 resistor select not written");
  switch_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_14
    wr_hit(wr_en, addr, OFF_PATH)
    |=> {amp1_neg_input_switch, stage2_cap_switch, stage2_res_switch} == $past(wdata[7:5]))
    else $error("analog switches not written");
  conv_en0_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_17
    wr_hit(wr_en, addr, OFF_DACC0)
    |=> converter_enable[0] == $past(wdata[BIT_CONV_EN]))
    else $error("first converter enable not written");

  // Converter loads; a start pulse without a high write would glitch the output
  code1_load_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
    wr_hit(wr_en, addr, OFF_DAH1)
    |=> conv_start[1] && converter_code1[11:8] == $past(wdata[3:0]))
    else $error("second high write did not load code");
  start_quiet0_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    !wr_hit(wr_en, addr, OFF_DAH0)
    |=> !conv_start[0])
    else $error("conversion started without high write");
  start_quiet1_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    !wr_hit(wr_en, addr, OFF_DAH1)
    |=> !conv_start[1])
    else $error("second conversion started without high write");
  shadow_hold0_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_16
    wr_hit(wr_en, addr, OFF_DAL0)
    |=> $stable(converter_code0))
    else $error("low write changed first active code");
  shadow_copy_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_16
    wr_hit(wr_en, addr, OFF_DAL1) ##1 !wr_hit(wr_en, addr, OFF_DAL1) ##1 wr_hit(wr_en, addr, OFF_DAH1)
    |=> converter_code1[7:0] == $past(wdata, 3))
    else $error("shadow byte not copied on high write");

  // Read side
  flag_follow0_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    rd_en && addr == OFF_CTRL0
    |=> rdata[7] == $past(amp_out[0] & offset_cal_mode[0]))
    else $error("first flag does not follow amplifier");
  flag_zero1_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
    rd_en && addr == OFF_CTRL1 && !offset_cal_mode[1]
    |=> !rdata[7])
    else $error("second flag set outside calibration");
  dah_read_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
    rd_en && (addr == OFF_DAH0 || addr == OFF_DAH1)
    |=> rdata[7:4] == 4'h0)
    else $error("high data upper bits nonzero");
  dacc_read_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_17
    rd_en && (addr == OFF_DACC0 || addr == OFF_DACC1)
    |=> rdata[6:0] == 7'h00)
    else $error("converter control unused bits nonzero");
  path_read_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_18
    rd_en && addr == OFF_PATH
    |=> rdata == $past({amp1_neg_input_switch, stage2_cap_switch, stage2_res_switch, path_q[4:0]}))
    else $error("path register read back wrong");
  unmapped_rd_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_18
    rd_en && addr > OFF_PATH
    |=> rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_18
    !rd_en
    |=> rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ---- tb_afe_opamp_dac_control.sv ----
// Self-checking testbench for the front-end control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_afe_opamp_dac_control;
  import afe_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic [1:0] amp_out = 2'h0;
  logic [1:0] amp_enable, offset_cal_mode, cal_reference_sel, converter_enable, conv_start;
  logic [3:0] amp_bandwidth_sel;
  logic [11:0] offset_trim_code, converter_code0, converter_code1;
  logic amp1_neg_input_switch, stage2_cap_switch, stage2_res_switch;
  logic [1:0] stage1_feedback_res_sel;
  logic [2:0] stage2_gain_res_sel;
  logic [7:0] rv;
  int err_total = 0;
  int comparisons = 0;
  // Control bits 5:2 and the flag are written high to prove they are dropped
  row_t rows [10] = '{
    '{OFF_CTRL0, 8'hff, 8'h43}, '{OFF_CTRL1, 8'h41, 8'h41}, '{OFF_CTRL1, 8'h7e, 8'h42},
    '{OFF_CTRL1, 8'hfd, 8'h41}, '{OFF_TRIM0, 8'hc5, 8'hc5}, '{OFF_TRIM1, 8'h3f, 8'h3f},
    '{OFF_PATH, 8'ha5, 8'ha5}, '{OFF_PATH, 8'h5a, 8'h5a}, '{OFF_DACC0, 8'hff, 8'h80},
    '{OFF_DACC1, 8'h80, 8'h80}};
  afe_opamp_dac_control #(.N_CH(2)) dut_u (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .amp_out(amp_out), .amp_enable(amp_enable),
    .amp_bandwidth_sel(amp_bandwidth_sel), .offset_cal_mode(offset_cal_mode),
    .cal_reference_sel(cal_reference_sel), .offset_trim_code(offset_trim_code),
    .amp1_neg_input_switch(amp1_neg_input_switch), .stage2_cap_switch(stage2_cap_switch),
    .stage2_res_switch(stage2_res_switch), .stage1_feedback_res_sel(stage1_feedback_res_sel),
    .stage2_gain_res_sel(stage2_gain_res_sel), .converter_enable(converter_enable),
    .converter_code0(converter_code0), .converter_code1(converter_code1),
    .conv_start(conv_start));
  always #20 core_clk = ~core_clk;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // Read data only stand in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic stop_test();
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #50000;
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK(offset_trim_code, 12'h820)
    `CHK({amp_enable, amp_bandwidth_sel, converter_enable}, 8'h00)
    rd(OFF_TRIM1, rv);
    `CHK(rv, 8'h20)
    rd(OFF_PATH, rv);
    `CHK(rv, 8'h00)
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      `CHK(rv, rows[i].e)
    end
    `CHK({amp_enable, amp_bandwidth_sel}, 6'h37)
    `CHK({offset_cal_mode, cal_reference_sel}, 4'h5)
    `CHK(offset_trim_code, {6'h3f, 6'h05})
    `CHK({amp1_neg_input_switch, stage2_cap_switch, stage2_res_switch}, 3'b010)
    `CHK({stage1_feedback_res_sel, stage2_gain_res_sel}, 5'b11010)
    `CHK(converter_enable, 2'b11)
    // Unmapped offsets must read zero and leave everything alone
    wr(4'hb, 8'hff);
    rd(4'hb, rv);
    `CHK(rv, 8'h00)
    `CHK({stage1_feedback_res_sel, stage2_gain_res_sel}, 5'b11010)
    // Flag follows the comparator only on the channel in calibration
    @(posedge core_clk);
    amp_out <= 2'b11;
    rd(OFF_CTRL0, rv);
    `CHK(rv, 8'hc3)
    rd(OFF_CTRL1, rv);
    `CHK(rv, 8'h41)
    @(posedge core_clk);
    amp_out <= 2'b00;
    rd(OFF_CTRL0, rv);
    `CHK(rv, 8'h43)
    // Low byte waits in the shadow until the high write
    wr(OFF_DAL0, 8'hab);
    `CHK({converter_code0, conv_start}, 14'h0)
    rd(OFF_DAL0, rv);
    `CHK(rv, 8'h00)
    wr(OFF_DAH0, 8'hf5);
    `CHK({converter_code0, conv_start}, {12'h5ab, 2'b01})
    @(posedge core_clk);
    #1;
    `CHK(conv_start, 2'b00)
    rd(OFF_DAH0, rv);
    `CHK(rv, 8'h05)
    rd(OFF_DAL0, rv);
    `CHK(rv, 8'hab)
    wr(OFF_DAL1, 8'h34);
    wr(OFF_DAH1, 8'h12);
    `CHK({converter_code1, converter_code0, conv_start}, {12'h234, 12'h5ab, 2'b10})
    // Reset in mid-run restores every field
    @(posedge core_clk);
    rst <= 1'b1;
    #1;
    `CHK({converter_code1, converter_code0, converter_enable}, 26'h0)
    `CHK(offset_trim_code, 12'h820)
    @(posedge core_clk);
    rst <= 1'b0;
    rd(OFF_CTRL0, rv);
    `CHK(rv, 8'h00)
    stop_test();
  end
endmodule
`default_nettype wire
